// ==== hw/serial_port.sv ====
// Purpose: Half-duplex start-stop serial port with delimiters
// Assumes: Inputs synchronous to CLK_IN; far end matches format
// Notes:   Transmit and receive are mutually exclusive
`default_nettype none
// Summary of operation
// - Start-stop framing, half duplex, never both ways
// - Seven selectable rates from 2400 to 115200
// - 7/8 data, none/even/odd parity, 1/2 stops
// - STX and end codes only in general mode
// - Switch zero: station from configuration value
// - Switch nonzero: switch wins, configuration ignored
// - Switch station numbers capped at 31
// - Switch station shared by both ports
// - Token-passing peer mode forces 115200
// - Cassette two-wire port: 19200 or 115200 only
// - Station count limits 99, adapter 32
module serial_port
    import serial_port_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire logic [2:0] BAUD_SEL_IN,
    input wire logic DATA8_IN,
    input wire logic [1:0] PARITY_IN,
    input wire logic STOP2_IN,
    input wire logic GENERAL_MODE_IN,
    input wire logic STX_EN_IN,
    input wire logic [1:0] END_CODE_IN,
    input wire logic PEER_MODE_IN,
    input wire logic CASSETTE_IN,
    input wire logic [STN_W-1:0] STN_SWITCH_IN,
    input wire logic [STN_W-1:0] STN_CONFIG_IN,
    input wire logic TX_VALID_IN,
    input wire logic [7:0] TX_DATA_IN,
    input wire logic TX_LAST_IN,
    input wire logic RXD_IN,
    output logic TX_READY_OUT,
    output logic TXD_OUT,
    output logic TX_EN_OUT,
    output logic RX_VALID_OUT,
    output logic [7:0] RX_DATA_OUT,
    output logic RX_PARITY_ERR_OUT,
    output logic RX_FRAME_ERR_OUT,
    output logic [STN_W-1:0] STATION_OUT,
    output logic BUSY_OUT
);
    typedef enum {
        S_IDLE, S_TX_LEAD, S_TX_BODY, S_TX_END1, S_TX_END2,
        S_TX_SHIFT, S_RX_SHIFT
    } state_t;
    state_t state_q, ret_q;
    serial_bit_if bit_bus();
    baud_tick_gen u_tick (
        .clk_in(CLK_IN),
        .rst_in(RST_IN),
        .bus(bit_bus)
    );
    // ==========================================================
    // Baud selection
    // Peer mode overrides, the cassette port has two legal rates and
    // codes up to 38400 fall to 19200 and faster codes to 115200
    baud_t cfg_baud, eff_baud;
    assign cfg_baud = baud_t'(BAUD_SEL_IN);
    always_comb begin
        eff_baud = (cfg_baud > BAUD_115200) ? BAUD_115200 : cfg_baud;
        if (PEER_MODE_IN) begin
            eff_baud = BAUD_115200;
        end else if (CASSETTE_IN) begin
            eff_baud = (cfg_baud > BAUD_38400) ? BAUD_115200
                                               : BAUD_19200;
        end
    end
    logic [BAUD_W-1:0] baud_q;
    assign bit_bus.div = baud_div(baud_t'(baud_q));
    // Divider waits in reload outside a character, so each start bit
    // begins on a fresh tick phase; a free-running phase would cut the
    // start bit by up to one tick
    wire in_char = (state_q == S_TX_SHIFT) || (state_q == S_RX_SHIFT);
    assign bit_bus.restart = !in_char;
    // ==========================================================
    // Station number selection, switch capped at STN_SW_MAX, configuration at STN_MULTI_MAX
    wire sw_used = (STN_SWITCH_IN != '0);
    wire [STN_W-1:0] sw_val = (STN_SWITCH_IN > STN_SW_MAX) ?
        STN_SW_MAX : STN_SWITCH_IN;
    wire [STN_W-1:0] cfg_val = (STN_CONFIG_IN > STN_MULTI_MAX) ?
        STN_MULTI_MAX : STN_CONFIG_IN;
    wire [STN_W-1:0] stn_d = sw_used ? sw_val : cfg_val;
    // ==========================================================
    // Frame geometry from format settings
    wire par_on = (parity_t'(PARITY_IN) == PAR_EVEN) ||
                  (parity_t'(PARITY_IN) == PAR_ODD);
    wire par_odd = (parity_t'(PARITY_IN) == PAR_ODD);
    // Bits after start: data, parity, stop(s)
    wire [3:0] nbits = 4'(DATA8_IN ? 8 : 7) + 4'(par_on) +
                       4'(STOP2_IN ? 2 : 1);
    // Build a shift word LSB first: data, parity, stops
    function automatic logic [11:0] frame(input logic [7:0] ch);
        logic [7:0] d;
        logic p;
        d = DATA8_IN ? ch : {1'b0, ch[6:0]};
        p = ^d ^ par_odd;
        frame = '1;
        if (DATA8_IN) begin
            frame[7:0] = d;
            if (par_on) frame[8] = p;
        end else begin
            frame[6:0] = d[6:0];
            if (par_on) frame[7] = p;
        end
    endfunction
    // ==========================================================
    // Shared shifter for both directions; only one runs at a time
    logic [11:0] sh_q;
    logic [3:0] bit_q;
    logic [3:0] ph_q;
    logic started_q;
    logic txd_q, txen_q, rdy_q;
    logic rxv_q, perr_q, ferr_q;
    logic [7:0] rxd_q;
    logic last_q;
    logic [1:0] endc_q;
    logic [STN_W-1:0] stn_q;
    wire tick = bit_bus.tick;
    wire ph_end = tick && (ph_q == 4'(OVS - 1));
    wire ph_mid = tick && (ph_q == 4'(OVS / 2 - 1));
    wire gen_stx = GENERAL_MODE_IN && STX_EN_IN;
    wire gen_end = GENERAL_MODE_IN &&
                   (end_code_t'(END_CODE_IN) != END_NONE);
    logic [7:0] end1_ch;
    always_comb begin
        case (end_code_t'(endc_q))
            END_ETX: end1_ch = CH_ETX;
            default: end1_ch = CH_CR;
        endcase
    end
    // Received fields split by format
    wire [7:0] rx_char = DATA8_IN ? sh_q[7:0] : {1'b0, sh_q[6:0]};
    wire rx_par = DATA8_IN ? sh_q[8] : sh_q[7];
    wire [3:0] stop_pos = 4'(DATA8_IN ? 8 : 7) + 4'(par_on);
    wire rx_stop_ok = sh_q[stop_pos] &&
                      (!STOP2_IN || sh_q[stop_pos + 4'd1]);
    // ==========================================================
    // Main sequencer
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            state_q <= S_IDLE;
            ret_q <= S_IDLE;
            sh_q <= '1;
            bit_q <= '0;
            ph_q <= '0;
            started_q <= 1'b0;
            txd_q <= 1'b1;
            txen_q <= 1'b0;
            rdy_q <= 1'b0;
            rxv_q <= 1'b0;
            perr_q <= 1'b0;
            ferr_q <= 1'b0;
            rxd_q <= '0;
            last_q <= 1'b0;
            endc_q <= '0;
            stn_q <= '0;
            baud_q <= BAUD_W'(BAUD_9600);
        end else begin
            rxv_q <= 1'b0;
            rdy_q <= 1'b0;
            stn_q <= stn_d;
            if (state_q == S_IDLE) baud_q <= BAUD_W'(eff_baud);
            if (tick) ph_q <= ph_q + 4'd1;
            case (state_q)
                S_IDLE: begin
                    txen_q <= 1'b0;
                    txd_q <= 1'b1;
                    ph_q <= '0;
                    // Receive takes priority; line is half duplex
                    if (!RXD_IN) begin
                        state_q <= S_RX_SHIFT;
                        started_q <= 1'b0;
                        bit_q <= '0;
                    end else if (TX_VALID_IN) begin
                        endc_q <= END_CODE_IN;
                        state_q <= gen_stx ? S_TX_LEAD : S_TX_BODY;
                    end
                end
                S_TX_LEAD: begin
                    sh_q <= frame(CH_STX);
                    ret_q <= S_TX_BODY;
                    state_q <= S_TX_SHIFT;
                    bit_q <= '0;
                    started_q <= 1'b0;
                    ph_q <= '0;
                end
                S_TX_BODY: begin
                    if (TX_VALID_IN) begin
                        rdy_q <= 1'b1;
                        sh_q <= frame(TX_DATA_IN);
                        last_q <= TX_LAST_IN;
                        ret_q <= (TX_LAST_IN && gen_end) ? S_TX_END1
                                : (TX_LAST_IN ? S_IDLE : S_TX_BODY);
                        state_q <= S_TX_SHIFT;
                        bit_q <= '0;
                        started_q <= 1'b0;
                        ph_q <= '0;
                    end
                end
                S_TX_END1: begin
                    sh_q <= frame(end1_ch);
                    ret_q <= (end_code_t'(endc_q) == END_CRLF) ?
                             S_TX_END2 : S_IDLE;
                    state_q <= S_TX_SHIFT;
                    bit_q <= '0;
                    started_q <= 1'b0;
                    ph_q <= '0;
                end
                S_TX_END2: begin
                    sh_q <= frame(CH_LF);
                    ret_q <= S_IDLE;
                    state_q <= S_TX_SHIFT;
                    bit_q <= '0;
                    started_q <= 1'b0;
                    ph_q <= '0;
                end
                S_TX_SHIFT: begin
                    txen_q <= 1'b1;
                    if (!started_q) begin
                        txd_q <= 1'b0;
                        started_q <= 1'b1;
                    end else if (ph_end) begin
                        if (bit_q == nbits) begin
                            state_q <= ret_q;
                        end else begin
                            txd_q <= sh_q[0];
                            sh_q <= {1'b1, sh_q[11:1]};
                            bit_q <= bit_q + 4'd1;
                        end
                    end
                end
                S_RX_SHIFT: begin
                    if (ph_mid) begin
                        if (!started_q) begin
                            // False start: glitch shorter than half a bit
                            if (RXD_IN) state_q <= S_IDLE;
                            started_q <= 1'b1;
                        end else begin
                            sh_q[bit_q] <= RXD_IN;
                            bit_q <= bit_q + 4'd1;
                            if (bit_q == nbits - 4'd1) begin
                                state_q <= S_IDLE;
                                rxv_q <= 1'b1;
                            end
                        end
                    end
                end
                default: state_q <= S_IDLE;
            endcase
            // Error flags report on the completed character
            if (rxv_q) begin
                rxd_q <= rx_char;
                perr_q <= par_on && (rx_par != (^rx_char ^ par_odd));
                ferr_q <= !rx_stop_ok;
            end
        end
    end
    // Delay valid one cycle so data and flags line up with it
    logic rxv2_q;
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) rxv2_q <= 1'b0;
        else rxv2_q <= rxv_q;
    end
    assign TX_READY_OUT = rdy_q;
    assign TXD_OUT = txd_q;
    assign TX_EN_OUT = txen_q;
    assign RX_VALID_OUT = rxv2_q;
    assign RX_DATA_OUT = rxd_q;
    assign RX_PARITY_ERR_OUT = perr_q;
    assign RX_FRAME_ERR_OUT = ferr_q;
    assign STATION_OUT = stn_q;
    assign BUSY_OUT = (state_q != S_IDLE);
endmodule
`default_nettype wire

// ==== hw/serial_port_pkg.sv ====
// Purpose: Shared constants and types for the controller serial port
// Assumes: 250 MHz system clock, one clock domain
// Notes:   Baud codes, delimiter codes and station limits live here
`default_nettype none
package serial_port_pkg;
    // ==========================================================
    // Clock and baud
    localparam int unsigned CLK_HZ = 250_000_000;
    localparam int unsigned OVS = 16;
    localparam int unsigned BAUD_W = 3;
    typedef enum logic [2:0] {
        BAUD_2400, BAUD_4800, BAUD_9600, BAUD_19200,
        BAUD_38400, BAUD_57600, BAUD_115200
    } baud_t;
    localparam int unsigned DIV_W = 16;
    // Oversample divisor for a given rate, rounded down
    function automatic logic [DIV_W-1:0] baud_div(input baud_t b);
        int unsigned bps;
        case (b)
            BAUD_2400: bps = 2400;
            BAUD_4800: bps = 4800;
            BAUD_9600: bps = 9600;
            BAUD_19200: bps = 19200;
            BAUD_38400: bps = 38400;
            BAUD_57600: bps = 57600;
            default: bps = 115200;
        endcase
        return DIV_W'(CLK_HZ / (bps * OVS));
    endfunction
    // ==========================================================
    // Character format
    typedef enum logic [1:0] {PAR_NONE, PAR_EVEN, PAR_ODD} parity_t;
    typedef enum logic [1:0] {
        END_CR, END_CRLF, END_NONE, END_ETX
    } end_code_t;
    localparam logic [7:0] CH_STX = 8'h02;
    localparam logic [7:0] CH_ETX = 8'h03;
    localparam logic [7:0] CH_CR = 8'h0D;
    localparam logic [7:0] CH_LF = 8'h0A;
    // ==========================================================
    // Station numbers
    localparam int unsigned STN_W = 7;
    localparam logic [STN_W-1:0] STN_SW_MAX = 7'h1F;
    localparam logic [STN_W-1:0] STN_MULTI_MAX = 7'h63;
    localparam logic [STN_W-1:0] STN_ADAPTER_MAX = 7'h20;
endpackage
`default_nettype wire

// ==== hw/serial_bit_if.sv ====
// Purpose: Bundle between the port core and its baud divider
// Assumes: Single clock
// Notes:   Divider reports one-cycle oversample ticks
`default_nettype none
interface serial_bit_if;
    import serial_port_pkg::*;
    logic [DIV_W-1:0] div;
    logic restart;
    logic tick;
    modport core (output div, output restart, input tick);
    modport gen (input div, input restart, output tick);
endinterface
`default_nettype wire

// ==== hw/baud_tick_gen.sv ====
// Purpose: Oversample tick divider for the serial port
// Assumes: div is at least one
// Notes:   restart holds the count at reload until a character starts
`default_nettype none
module baud_tick_gen
    import serial_port_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    serial_bit_if.gen bus
);
    logic [DIV_W-1:0] cnt_q;
    logic tick_q;
    wire wrap = (cnt_q == '0);
    // ==========================================================
    // Down counter; a tick on each wrap
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else if (bus.restart) begin
            // Reload, so the first tick lands one full period after release
            cnt_q <= bus.div - 1'b1;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= wrap ? bus.div - 1'b1 : cnt_q - 1'b1;
            tick_q <= wrap;
        end
    end
    assign bus.tick = tick_q;
endmodule
`default_nettype wire

// ==== test/serial_host_model.sv ====
// Purpose: Far-end station model for the serial port bench
// Assumes: Same clock as the port; bit time given in clocks
// Notes:   Receiver samples mid-bit and logs the first low run
`default_nettype none
module serial_host_model #(
    parameter int BIT_CYC = 2160
) (
    input wire logic clk_in,
    input wire logic txd_in,
    output logic rxd_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int rx_len = 8;
    logic [9:0] rx_q[$];
    int run_q[$];
    // ==========================================================
    // Sender
    // Line rests at mark between characters
    initial rxd_out = 1'b1;
    // Start bit, n bits LSB first, then mark; bench never overlaps TX
    task automatic send(input logic [9:0] bits, input int n);
        @(posedge clk_in);
        #1 rxd_out = 1'b0;
        repeat (BIT_CYC) @(posedge clk_in);
        for (int i = 0; i < n; i++) begin
            #1 rxd_out = bits[i];
            repeat (BIT_CYC) @(posedge clk_in);
        end
        #1 rxd_out = 1'b1;
    endtask
    // ==========================================================
    // Receiver
    // Ends mid-stop so a back-to-back start edge is not missed
    always begin
        logic [9:0] v;
        int n;
        @(negedge txd_in);
        v = '0;
        n = 0;
        for (int c = 1; c <= BIT_CYC * rx_len + BIT_CYC / 2; c++) begin
            @(posedge clk_in);
            if (n == 0 && txd_in === 1'b1) n = c;
            if (c > BIT_CYC && (c - BIT_CYC / 2) % BIT_CYC == 0)
                v[(c - BIT_CYC / 2) / BIT_CYC - 1] = txd_in;
        end
        rx_q.push_back(v);
        run_q.push_back(n);
    end
endmodule
`default_nettype wire

// ==== test/serial_port_assertions.sv ====
// Purpose: Port checks for the serial port
// Assumes: One clock, reset synchronous and high
// Notes:   Bound to every serial_port instance
`default_nettype none
module serial_port_assertions
    import serial_port_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire logic [STN_W-1:0] STN_SWITCH_IN,
    input wire logic [STN_W-1:0] STN_CONFIG_IN,
    input wire logic TX_VALID_IN,
    input wire logic TX_READY_OUT,
    input wire logic TXD_OUT,
    input wire logic TX_EN_OUT,
    input wire logic RX_VALID_OUT,
    input wire logic [7:0] RX_DATA_OUT,
    input wire logic [STN_W-1:0] STATION_OUT,
    input wire logic BUSY_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);
    // ==========================================================
    // Line and handshakes
    // A start bit spans many clocks, so a short dip is a fault
    sequence s_start_low;
        !TXD_OUT [*8];
    endsequence
    a_reset_idle: assert property (
        $fell(RST_IN) |-> TXD_OUT && !TX_EN_OUT && !BUSY_OUT)
        else $error("line not idle after reset");
    a_idle_mark: assert property (
        !TX_EN_OUT |-> TXD_OUT) else $error("line low while released");
    a_start_hold: assert property (
        $fell(TXD_OUT) |-> s_start_low) else $error("start bit too short");
    a_no_rx_in_tx: assert property (
        TX_EN_OUT |-> !RX_VALID_OUT) else $error("receive while sending");
    a_ready_pulse: assert property (
        TX_READY_OUT |=> !TX_READY_OUT) else $error("ready too long");
    a_ready_offer: assert property (
        TX_READY_OUT |-> $past(TX_VALID_IN)) else $error("ready unasked");
    a_rx_pulse: assert property (
        RX_VALID_OUT |=> !RX_VALID_OUT) else $error("rx valid too long");
    a_rx_data_hold: assert property (
        RX_VALID_OUT |=> $stable(RX_DATA_OUT) [*8])
        else $error("rx data not held");
    // ==========================================================
    // Station number
    a_stn_config: assert property (
        STN_SWITCH_IN == 0 && STN_CONFIG_IN <= STN_MULTI_MAX
        |=> STATION_OUT == $past(STN_CONFIG_IN))
        else $error("station not from config");
    a_stn_switch: assert property (
        STN_SWITCH_IN != 0 && STN_SWITCH_IN <= STN_SW_MAX
        |=> STATION_OUT == $past(STN_SWITCH_IN))
        else $error("station not from switch");
    a_stn_cap: assert property (
        STN_SWITCH_IN > STN_SW_MAX |=> STATION_OUT == STN_SW_MAX)
        else $error("switch station not capped");
endmodule
bind serial_port serial_port_assertions chk_u (
    .CLK_IN, .RST_IN, .STN_SWITCH_IN, .STN_CONFIG_IN, .TX_VALID_IN,
    .TX_READY_OUT, .TXD_OUT, .TX_EN_OUT, .RX_VALID_OUT, .RX_DATA_OUT,
    .STATION_OUT, .BUSY_OUT
);
`default_nettype wire

// ==== test/plc_serial_port_config_tb.sv ====
// Purpose: Self-checking bench for the serial port
// Assumes: 250 MHz clock, far end modelled by serial_host_model
// Notes:   Baud divider is fixed, so only a few characters fit
`default_nettype none
module plc_serial_port_config_tb;
    import serial_port_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BIT_CYC = OVS * (CLK_HZ / (115200 * OVS));
    logic clk = 1'b0, rst = 1'b1, d8 = 1'b1, stop2 = 1'b0, gen = 1'b0;
    logic stx = 1'b0, peer = 1'b1, cas = 1'b0, tv = 1'b0, tl = 1'b0;
    logic [2:0] baud = 3'h0;
    logic [1:0] par = 2'h1, endc = 2'h0;
    logic [STN_W-1:0] sw = 7'h00, cfg = 7'h00, stn;
    logic [7:0] td = 8'h00, rd;
    logic trdy, txd, txen, rv, pe, fe, busy;
    wire logic rxd;
    logic [6:0] tsw[4] = '{7'h00, 7'h09, 7'h28, 7'h00};
    logic [6:0] tcfg[4] = '{7'h2D, 7'h2D, 7'h2D, 7'h78};
    logic [6:0] texp[4] = '{7'h2D, 7'h09, 7'h1F, 7'h63};
    logic [9:0] rxf[2] = '{10'h3A5, 10'h13C};
    logic [7:0] tch[3] = '{CH_STX, 8'h41, CH_ETX};
    int n_mismatch = 0;
    int samples_checked = 0;
    serial_port dut_u (.CLK_IN(clk), .RST_IN(rst), .BAUD_SEL_IN(baud),
        .DATA8_IN(d8), .PARITY_IN(par), .STOP2_IN(stop2),
        .GENERAL_MODE_IN(gen), .STX_EN_IN(stx), .END_CODE_IN(endc),
        .PEER_MODE_IN(peer), .CASSETTE_IN(cas), .STN_SWITCH_IN(sw),
        .STN_CONFIG_IN(cfg), .TX_VALID_IN(tv), .TX_DATA_IN(td),
        .TX_LAST_IN(tl), .RXD_IN(rxd), .TX_READY_OUT(trdy),
        .TXD_OUT(txd), .TX_EN_OUT(txen), .RX_VALID_OUT(rv),
        .RX_DATA_OUT(rd), .RX_PARITY_ERR_OUT(pe), .RX_FRAME_ERR_OUT(fe),
        .STATION_OUT(stn), .BUSY_OUT(busy));
    serial_host_model #(.BIT_CYC(BIT_CYC)) host_u (.clk_in(clk),
        .txd_in(txd), .rxd_out(rxd));
    // ==========================================================
    // Clock, compare and closing
    initial forever #2 clk = ~clk;
    task automatic check(input string nm, input logic [15:0] e,
                         input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Offer is held until ready is sampled high at an edge
    task automatic put_byte(input logic [7:0] b, input logic last);
        tv = 1'b1;
        td = b;
        tl = last;
        for (int k = 0; k < 40000; k++) begin
            @(posedge clk);
            if (trdy === 1'b1) break;
        end
        check("tx ready", 16'h1, {15'h0, trdy});
        #1 tv = 1'b0;
    endtask
    // Valid is a one-cycle pulse, so look in every cycle
    task automatic wait_rx;
        for (int k = 0; k < 30000 && rv !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        check("rx valid", 16'h1, {15'h0, rv});
    endtask
    // Long characters need well under this span
    initial begin
        #600000;
        n_mismatch++;
        report_and_stop;
    end
    // ==========================================================
    // Tests
    initial begin
        repeat (12) @(posedge clk);
        #1 rst = 1'b0;
        @(posedge clk);
        #1;
        check("txd idle", 16'h1, {15'h0, txd});
        check("tx_en idle", 16'h0, {15'h0, txen});
        check("busy idle", 16'h0, {15'h0, busy});
        for (int i = 0; i < 4; i++) begin
            sw = tsw[i];
            cfg = tcfg[i];
            repeat (2) @(posedge clk);
            #1;
            check("station", {9'h0, texp[i]}, {9'h0, stn});
        end
        $display("test station done");
        // Peer mode with the slowest code must still run at 115200
        for (int i = 0; i < 2; i++) begin
            // Even parity with a bad parity bit, then odd with a bad stop
            par = (i == 0) ? 2'h1 : 2'h2;
            fork
                host_u.send(rxf[i], 10);
                wait_rx;
            join
            check("rx data", {8'h0, rxf[i][7:0]}, {8'h0, rd});
            check("parity err", 16'(1 - i), {15'h0, pe});
            check("frame err", 16'(i), {15'h0, fe});
        end
        $display("test receive done");
        peer = 1'b0;
        baud = 3'h6; // No adapter or cassette on this line
        d8 = 1'b0;
        par = 2'h0;
        gen = 1'b1;
        stx = 1'b1;
        endc = 2'h3;
        host_u.rx_q.delete();
        host_u.run_q.delete();
        repeat (4) @(posedge clk);
        #1;
        put_byte(8'h41, 1'b1);
        for (int k = 0; k < 80000 && host_u.rx_q.size() < 3; k++)
            @(posedge clk);
        #1;
        check("tx count", 16'h3, 16'(host_u.rx_q.size()));
        for (int i = 0; i < 3 && i < host_u.rx_q.size(); i++) begin
            check("tx char", {8'h0, 1'b1, tch[i][6:0]},
                  {6'h0, host_u.rx_q[i]});
            check("bit time", 16'h1, 16'((host_u.run_q[i] -
                  (i == 0 ? 2 : 1) * BIT_CYC) inside {[-2:2]}));
        end
        $display("test transmit done");
        report_and_stop;
    end
endmodule
`default_nettype wire
